// >>> inc/mfio_params.svh
`ifndef MFIO_PARAMS_SVH
`define MFIO_PARAMS_SVH
// Overview of operation
// - Waveform buffer holds 2048 samples, any length.
// - Active channels share length; length capped.
// - Two waveform channels, analog 0 and 1, concurrent.
// - Advance clock: software, line 20, counter/timers.
// - Each advance emits one frame, all active channels.
// - Forty-eight lines in six eight-bit ports.
// - Ports A-E one direction; F per bit.
// - Reset makes every line an input.
// - Two counter/timers, 32 bits each.
// - Counter counts line events; timer makes pulses.
// - Pulse polarity and width 1/10/100/1000 programmable.
// - Timer clock is 50 MHz or 1 MHz.
// - Divisor spans one up to full 32 bits.
// - Counter/timer takes its line, sets direction.
// - Counter/timers use shared lines two and three.
// - Four 24-bit modulators, period, duty, polarity.
// - Active level first for duty, then opposite.
// - One period counter and one duty counter.
// - Running enabled modulator forces its shared line out, unless a counter/timer takes that line.
// - Two-channel samples interleave as frames.
// - One-shot stops after one pass; continuous repeats.
// - Pause keeps position; reset stops, keeps buffer.

// Core clock and the slow timer clock.
`define CLK_HZ 50000000
`define SLOW_HZ 1000000
`define SLOW_DIV (`CLK_HZ / `SLOW_HZ)

// Register offsets.
`define REG_DIO_DIR 8'h00
`define REG_DIO_PORT0 8'h10
`define REG_WAVE_CFG 8'h40
`define REG_WAVE_LEN 8'h44
`define REG_WAVE_CMD 8'h48
`define REG_WAVE_ADDR 8'h4c
`define REG_WAVE_DATA 8'h50
`define REG_WAVE_STAT 8'h54
`define REG_CT_CTRL 4'h0
`define REG_CT_LOAD 4'h4
`define REG_CT_COUNT 4'h8
`define REG_PWM_CTRL 4'h0
`define REG_PWM_PERIOD 4'h4
`define REG_PWM_DUTY 4'h8

// Field positions.
`define WCFG_CONT 2
`define WCFG_TWO 3
`define CMD_START 0
`define CMD_PAUSE 1
`define CMD_RESET 2
`define CMD_INC 3
`define CT_EN 0
`define CT_TIMER 1
`define CT_SLOW 2
`define CT_OE 3
`define CT_POL 4
`define CT_WSEL 5
`define PWM_RUN 0
`define PWM_OE 1
`define PWM_POL 2

// Waveform clock sources.
`define WSRC_SW 2'h0
`define WSRC_EXT 2'h1
`define WSRC_CT0 2'h2
`define WSRC_CT1 2'h3

// Pulse widths less one, in timer clock periods.
`define PW_SEL0 10'h000
`define PW_SEL1 10'h009
`define PW_SEL2 10'h063
`define PW_SEL3 10'h3e7

// Shared line numbers.
`define LINE_WAVE_EXT 20
`define LINE_PWM0 40
`define LINE_CT0 42

// Reset values of the direction registers.
`define RST_DIR_AE 5'h00
`define RST_DIR_F 8'h00
`endif

// >>> inc/mfio_pkg.sv
package mfio_pkg;

    // Sequencer states, Gray coded along the frame path.
    typedef enum logic [2:0] {
        W_IDLE = 3'h0,
        W_ARMED = 3'h1,
        W_FETCH0 = 3'h3,
        W_FETCH1 = 3'h2,
        W_FETCH2 = 3'h6
    } wave_state_t;

    // Registered state of the core; the buffer and the modulators are kept outside it.
    typedef struct packed {
        logic [4:0] dir_ae;
        logic [7:0] dir_f;
        logic [47:0] out_lat;
        logic [1:0] w_src;
        logic w_cont;
        logic w_two;
        logic [11:0] w_len;
        logic [10:0] w_wptr;
        wave_state_t w_st;
        logic [10:0] w_frame;
        logic [10:0] w_raddr;
        logic prev_in20;
        logic [1:0] prev_ext;
        logic [5:0] slow_div;
        logic slow_en;
        logic [1:0][6:0] ct_ctrl;
        logic [1:0][31:0] ct_load;
        logic [1:0][31:0] ct_cnt;
        logic [1:0][9:0] ct_pw;
        logic [1:0] ct_pulse;
        logic [1:0] ct_evt;
        logic [3:0][2:0] pwm_ctrl;
        logic [3:0][23:0] pwm_per;
        logic [3:0][23:0] pwm_duty;
        logic [47:0] dio_o;
        logic [47:0] dio_oe;
        logic [15:0] dac0;
        logic dac0_stb;
        logic [15:0] dac1;
        logic dac1_stb;
        logic [31:0] rdata;
    } core_state_t;

    // State of one modulator.
    typedef struct packed {
        logic [23:0] per_cnt;
        logic [23:0] duty_cnt;
        logic level;
    } pwm_state_t;

endpackage : mfio_pkg

// >>> design/pwm_channel.sv
`include "mfio_params.svh"

module pwm_channel (
    input wire logic clk, // Core clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic run, // Modulator running.
    input wire logic pol_high, // Active level is high when set.
    input wire logic [23:0] period, // Period in core clock cycles.
    input wire logic [23:0] duty, // Active cycles per period.
    output logic level // Modulated level, from a flip-flop.
);

    mfio_pkg::pwm_state_t s, nxt;

    // Period counter runs down; the duty counter is reloaded at each period start.
    always_comb begin
        nxt = s;
        if (!run) begin
            nxt.per_cnt = 24'h0;
            nxt.duty_cnt = 24'h0;
            nxt.level = !pol_high;
        end else if (s.per_cnt == 24'h0) begin
            nxt.per_cnt = (period > 24'h1) ? period - 24'h1 : 24'h0;
            nxt.duty_cnt = (duty != 24'h0) ? duty - 24'h1 : 24'h0;
            nxt.level = (duty != 24'h0) ? pol_high : !pol_high;
        end else begin
            nxt.per_cnt = s.per_cnt - 24'h1;
            nxt.level = (s.duty_cnt != 24'h0) ? pol_high : !pol_high;
            if (s.duty_cnt != 24'h0) begin
                nxt.duty_cnt = s.duty_cnt - 24'h1;
            end
        end
    end

    // A stopped modulator rests at its inactive level.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    assign level = s.level;

    a_period_start: assert property (@(posedge clk) disable iff (!rst_n)
        (run && s.per_cnt == 24'h0 && duty != 24'h0) |=> (level == $past(pol_high)))
        else $error("Modulator not active at period start.");

    a_duty_one: assert property (@(posedge clk) disable iff (!rst_n)
        (run && s.per_cnt == 24'h0 && duty == 24'h1 && period > 24'h2) ##1 run |=> (level == !$past(pol_high, 2)))
        else $error("Modulator active beyond a one-cycle duty.");

endmodule : pwm_channel

// >>> design/mfio_core.sv
// Implementation choices: the register offsets and the plain strobed port.
`include "mfio_params.svh"

module mfio_core #(
    parameter int BUF_DEPTH = 2048 // Waveform samples held on board.
) (
    input wire logic CORE_CLK, // 50 MHz core clock.
    input wire logic RST_N, // Synchronous reset, active low.
    input wire logic [7:0] ADDR, // Register byte address.
    input wire logic [31:0] WDATA, // Register write data.
    input wire logic WR, // Write strobe.
    input wire logic RD, // Read strobe.
    output logic [31:0] RDATA, // Read data, cycle after the strobe.
    input wire logic [47:0] DIO_IN, // Levels seen on the lines.
    output logic [47:0] DIO_OUT, // Levels driven on the lines.
    output logic [47:0] DIO_OE, // High while a line is driven.
    output logic [15:0] DAC0_DATA, // Sample for analog channel 0.
    output logic DAC0_STB, // Sample 0 valid pulse.
    output logic [15:0] DAC1_DATA, // Sample for analog channel 1.
    output logic DAC1_STB, // Sample 1 valid pulse.
    output logic [1:0] CT_EVENT // Terminal count pulses.
);

    localparam int AW = $clog2(BUF_DEPTH);

    if (BUF_DEPTH < 2 || BUF_DEPTH > 2048 || (1 << AW) != BUF_DEPTH) begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two from 2 to 2048.");
    end

    mfio_pkg::core_state_t s, nxt;
    logic [15:0] wave_mem [BUF_DEPTH];
    logic [15:0] rd_q;
    logic [3:0] pwm_lvl;

    // A counter/timer drives its line only in timer mode with output on.
    function automatic logic ct_drives(input logic [6:0] c);
        return c[`CT_EN] && c[`CT_TIMER] && c[`CT_OE];
    endfunction : ct_drives

    // In counter mode the line is the event input.
    function automatic logic ct_listens(input logic [6:0] c);
        return c[`CT_EN] && !c[`CT_TIMER];
    endfunction : ct_listens

    // Frames in one pass, capped to what the buffer holds per channel.
    function automatic logic [11:0] frame_limit(input logic [11:0] len, input logic two);
        logic [11:0] cap;
        cap = two ? 12'(BUF_DEPTH / 2) : 12'(BUF_DEPTH);
        if (len < cap) begin
            cap = len;
        end
        return (cap == 12'h0) ? 12'h1 : cap;
    endfunction : frame_limit

    always_comb begin
        logic wtick;
        logic last;
        logic ctick;
        logic [10:0] base;
        nxt = s;
        wtick = 1'b0;
        last = 1'b0;
        ctick = 1'b0;
        base = 11'h0;
        nxt.dac0_stb = 1'b0;
        nxt.dac1_stb = 1'b0;
        nxt.ct_evt = 2'h0;
        nxt.rdata = 32'h0;
        nxt.prev_in20 = DIO_IN[`LINE_WAVE_EXT];
        nxt.prev_ext = DIO_IN[`LINE_CT0 +: 2];

        // The 1 MHz rate is a one-cycle enable every fiftieth cycle.
        if (s.slow_div == 6'(`SLOW_DIV - 1)) begin
            nxt.slow_div = 6'h0;
            nxt.slow_en = 1'b1;
        end else begin
            nxt.slow_div = s.slow_div + 6'h1;
            nxt.slow_en = 1'b0;
        end

        // Register writes.
        if (WR) begin
            case (ADDR)
                `REG_DIO_DIR: begin
                    nxt.dir_ae = WDATA[4:0];
                    nxt.dir_f = WDATA[15:8];
                end
                `REG_WAVE_CFG: begin
                    nxt.w_src = WDATA[1:0];
                    nxt.w_cont = WDATA[`WCFG_CONT];
                    nxt.w_two = WDATA[`WCFG_TWO];
                end
                `REG_WAVE_LEN: nxt.w_len = WDATA[11:0];
                `REG_WAVE_ADDR: nxt.w_wptr = WDATA[10:0];
                `REG_WAVE_DATA: nxt.w_wptr = s.w_wptr + 11'h1;
                default: ;
            endcase
            for (int p = 0; p < 6; p++) begin
                if (ADDR == `REG_DIO_PORT0 + 8'(4 * p)) begin
                    nxt.out_lat[8 * p +: 8] = WDATA[7:0];
                end
            end
            if (ADDR[7:5] == 3'h3) begin
                if (ADDR[3:0] == `REG_CT_CTRL) begin
                    nxt.ct_ctrl[ADDR[4]] = WDATA[6:0];
                end else if (ADDR[3:0] == `REG_CT_LOAD) begin
                    nxt.ct_load[ADDR[4]] = WDATA;
                end
            end
            if (ADDR[7:6] == 2'h2) begin
                if (ADDR[3:0] == `REG_PWM_CTRL) begin
                    nxt.pwm_ctrl[ADDR[5:4]] = WDATA[2:0];
                end else if (ADDR[3:0] == `REG_PWM_PERIOD) begin
                    nxt.pwm_per[ADDR[5:4]] = WDATA[23:0];
                end else if (ADDR[3:0] == `REG_PWM_DUTY) begin
                    nxt.pwm_duty[ADDR[5:4]] = WDATA[23:0];
                end
            end
        end

        // Register reads; unmapped addresses return zero.
        if (RD) begin
            case (ADDR)
                `REG_DIO_DIR: nxt.rdata = {16'h0, s.dir_f, 3'h0, s.dir_ae};
                `REG_WAVE_CFG: nxt.rdata = {28'h0, s.w_two, s.w_cont, s.w_src};
                `REG_WAVE_LEN: nxt.rdata = {20'h0, s.w_len};
                `REG_WAVE_ADDR: nxt.rdata = {21'h0, s.w_wptr};
                `REG_WAVE_STAT: nxt.rdata = {20'h0, s.w_frame, s.w_st != mfio_pkg::W_IDLE};
                default: ;
            endcase
            for (int p = 0; p < 6; p++) begin
                if (ADDR == `REG_DIO_PORT0 + 8'(4 * p)) begin
                    nxt.rdata = {24'h0, DIO_IN[8 * p +: 8]};
                end
            end
            if (ADDR[7:5] == 3'h3) begin
                if (ADDR[3:0] == `REG_CT_CTRL) begin
                    nxt.rdata = {25'h0, s.ct_ctrl[ADDR[4]]};
                end else if (ADDR[3:0] == `REG_CT_LOAD) begin
                    nxt.rdata = s.ct_load[ADDR[4]];
                end else if (ADDR[3:0] == `REG_CT_COUNT) begin
                    nxt.rdata = s.ct_cnt[ADDR[4]];
                end
            end
            if (ADDR[7:6] == 2'h2) begin
                if (ADDR[3:0] == `REG_PWM_CTRL) begin
                    nxt.rdata = {29'h0, s.pwm_ctrl[ADDR[5:4]]};
                end else if (ADDR[3:0] == `REG_PWM_PERIOD) begin
                    nxt.rdata = {8'h0, s.pwm_per[ADDR[5:4]]};
                end else if (ADDR[3:0] == `REG_PWM_DUTY) begin
                    nxt.rdata = {8'h0, s.pwm_duty[ADDR[5:4]]};
                end
            end
        end

        // Counter/timers: both modes count down and reload on terminal count.
        for (int n = 0; n < 2; n++) begin
            if (s.ct_ctrl[n][`CT_TIMER]) begin
                ctick = s.ct_ctrl[n][`CT_SLOW] ? s.slow_en : 1'b1;
            end else begin
                ctick = DIO_IN[`LINE_CT0 + n] && !s.prev_ext[n];
            end
            if (!s.ct_ctrl[n][`CT_EN]) begin
                nxt.ct_cnt[n] = s.ct_load[n] - 32'h1;
                nxt.ct_pulse[n] = 1'b0;
            end else if (ctick) begin
                if (s.ct_pw[n] != 10'h0) begin
                    nxt.ct_pw[n] = s.ct_pw[n] - 10'h1;
                end else begin
                    nxt.ct_pulse[n] = 1'b0;
                end
                if (s.ct_cnt[n] == 32'h0) begin
                    nxt.ct_cnt[n] = s.ct_load[n] - 32'h1;
                    nxt.ct_evt[n] = 1'b1;
                    nxt.ct_pulse[n] = 1'b1;
                    case (s.ct_ctrl[n][`CT_WSEL +: 2])
                        2'h0: nxt.ct_pw[n] = `PW_SEL0;
                        2'h1: nxt.ct_pw[n] = `PW_SEL1;
                        2'h2: nxt.ct_pw[n] = `PW_SEL2;
                        default: nxt.ct_pw[n] = `PW_SEL3;
                    endcase
                end else begin
                    nxt.ct_cnt[n] = s.ct_cnt[n] - 32'h1;
                end
            end
        end

        // Line ownership: direction registers, then modulators, then counter/timers.
        for (int i = 0; i < 40; i++) begin
            nxt.dio_oe[i] = s.dir_ae[i / 8];
        end
        nxt.dio_oe[47:40] = s.dir_f;
        nxt.dio_o = s.out_lat;
        for (int k = 0; k < 4; k++) begin
            if (s.pwm_ctrl[k][`PWM_RUN] && s.pwm_ctrl[k][`PWM_OE]) begin
                nxt.dio_oe[`LINE_PWM0 + k] = 1'b1;
                nxt.dio_o[`LINE_PWM0 + k] = pwm_lvl[k];
            end
        end
        for (int n = 0; n < 2; n++) begin
            if (ct_drives(s.ct_ctrl[n])) begin
                nxt.dio_oe[`LINE_CT0 + n] = 1'b1;
                nxt.dio_o[`LINE_CT0 + n] = s.ct_pulse[n] == s.ct_ctrl[n][`CT_POL];
            end else if (ct_listens(s.ct_ctrl[n])) begin
                nxt.dio_oe[`LINE_CT0 + n] = 1'b0;
            end
        end

        // Waveform advance source.
        unique case (s.w_src)
            `WSRC_SW: wtick = WR && ADDR == `REG_WAVE_CMD && WDATA[`CMD_INC];
            `WSRC_EXT: wtick = DIO_IN[`LINE_WAVE_EXT] && !s.prev_in20;
            `WSRC_CT0: wtick = s.ct_evt[0];
            `WSRC_CT1: wtick = s.ct_evt[1];
        endcase

        // Frames are interleaved, so a frame starts at twice its index with two channels.
        base = s.w_two ? {s.w_frame[9:0], 1'b0} : s.w_frame;
        last = {1'b0, s.w_frame} == frame_limit(s.w_len, s.w_two) - 12'h1;

        // Reading the buffer takes a cycle, so each sample is fetched one state ahead.
        unique case (s.w_st)
            mfio_pkg::W_IDLE: ;
            mfio_pkg::W_ARMED: begin
                if (wtick) begin
                    nxt.w_raddr = base;
                    nxt.w_st = mfio_pkg::W_FETCH0;
                end
            end
            mfio_pkg::W_FETCH0: begin
                nxt.w_raddr = base | 11'h1;
                nxt.w_st = mfio_pkg::W_FETCH1;
            end
            mfio_pkg::W_FETCH1: begin
                nxt.dac0 = rd_q;
                nxt.dac0_stb = 1'b1;
                nxt.w_st = s.w_two ? mfio_pkg::W_FETCH2 : mfio_pkg::W_ARMED;
            end
            mfio_pkg::W_FETCH2: begin
                nxt.dac1 = rd_q;
                nxt.dac1_stb = 1'b1;
                nxt.w_st = mfio_pkg::W_ARMED;
            end
            default: nxt.w_st = mfio_pkg::W_IDLE;
        endcase

        // Closing a frame; one-shot runs stop by themselves after the last one.
        if ((s.w_st == mfio_pkg::W_FETCH1 && !s.w_two) || s.w_st == mfio_pkg::W_FETCH2) begin
            if (last) begin
                nxt.w_frame = 11'h0;
                nxt.w_st = s.w_cont ? mfio_pkg::W_ARMED : mfio_pkg::W_IDLE;
            end else begin
                nxt.w_frame = s.w_frame + 11'h1;
            end
        end

        // Commands override sequencing: reset, then pause, then start.
        if (WR && ADDR == `REG_WAVE_CMD) begin
            if (WDATA[`CMD_RESET]) begin
                nxt.w_st = mfio_pkg::W_IDLE;
                nxt.w_frame = 11'h0;
            end else if (WDATA[`CMD_PAUSE]) begin
                nxt.w_st = mfio_pkg::W_IDLE;
                nxt.w_frame = s.w_frame;
            end else if (WDATA[`CMD_START] && s.w_st == mfio_pkg::W_IDLE) begin
                nxt.w_st = mfio_pkg::W_ARMED;
            end
        end
    end

    // The buffer is kept out of the state record; reset leaves its contents alone.
    always_ff @(posedge CORE_CLK) begin
        if (WR && ADDR == `REG_WAVE_DATA) begin
            wave_mem[s.w_wptr[AW-1:0]] <= WDATA[15:0];
        end
        rd_q <= wave_mem[s.w_raddr[AW-1:0]];
    end

    // State register; a reset makes every line an input.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s <= '0;
            s.dir_ae <= `RST_DIR_AE;
            s.dir_f <= `RST_DIR_F;
        end else begin
            s <= nxt;
        end
    end

    // Modulators, one per shared line zero to three. They follow the next control values, so the first level that
    // reaches a newly taken line already belongs to a period start rather than to the old rest level.
    for (genvar k = 0; k < 4; k++) begin : g_pwm
        pwm_channel u_pwm (
            .clk(CORE_CLK),
            .rst_n(RST_N),
            .run(nxt.pwm_ctrl[k][`PWM_RUN]),
            .pol_high(nxt.pwm_ctrl[k][`PWM_POL]),
            .period(nxt.pwm_per[k]),
            .duty(nxt.pwm_duty[k]),
            .level(pwm_lvl[k])
        );
    end

    // Every output is a flip-flop of the state record.
    assign RDATA = s.rdata;
    assign DIO_OUT = s.dio_o;
    assign DIO_OE = s.dio_oe;
    assign DAC0_DATA = s.dac0;
    assign DAC0_STB = s.dac0_stb;
    assign DAC1_DATA = s.dac1;
    assign DAC1_STB = s.dac1_stb;
    assign CT_EVENT = s.ct_evt;

    a_reset_all_input: assert property (@(posedge CORE_CLK)
        !RST_N |=> (DIO_OE == 48'h0))
        else $error("A line is driven after reset.");

    a_port_unison: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (DIO_OE[7:0] == 8'h00 || DIO_OE[7:0] == 8'hff) && (DIO_OE[39:32] == 8'h00 || DIO_OE[39:32] == 8'hff))
        else $error("Port bits disagree in direction.");

    a_frame_pair: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (DAC0_STB && s.w_two) |=> DAC1_STB)
        else $error("Second channel sample missing from frame.");

    a_single_frame: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (DAC0_STB && !s.w_two) |=> !DAC1_STB)
        else $error("Channel 1 written in one-channel mode.");

    a_ct_line_own: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (ct_listens(s.ct_ctrl[0]) && s.pwm_ctrl[2] == 3'h3) |=> !DIO_OE[`LINE_CT0])
        else $error("Modulator took a line held by a counter input.");

    a_ct_line_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (ct_drives(s.ct_ctrl[0]) |=> DIO_OE[`LINE_CT0]) and (ct_drives(s.ct_ctrl[1]) |=> DIO_OE[`LINE_CT0 + 1]))
        else $error("Timer output line not driven.");

    a_pwm_takeover: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (s.pwm_ctrl[0][`PWM_RUN] && s.pwm_ctrl[0][`PWM_OE]) |=> DIO_OE[`LINE_PWM0])
        else $error("Modulator line not forced to output.");

    a_slow_rate: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s.slow_en |-> ##50 s.slow_en)
        else $error("Slow enable not every fifty cycles.");

    a_slow_gap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s.slow_en |=> !s.slow_en [*8])
        else $error("Slow enable repeats too soon.");

endmodule : mfio_core

// >>> dv/far_side_model.sv
module far_side_model (
    input wire logic clk, // Core clock.
    input wire logic [47:0] dio_out, // Levels the core drives.
    input wire logic [47:0] dio_oe, // Lines the core drives.
    input wire logic [47:0] ext_val, // Levels driven from outside.
    input wire logic [47:0] ext_en, // Lines driven from outside.
    input wire logic dac0_stb, // Channel 0 sample strobe.
    output logic [47:0] dio_in, // Resolved line levels.
    output int frames // Frames taken by the converters.
);
    timeunit 1ns;
    timeprecision 1ps;

    // An undriven line floats to the pull-up level, never to a stale value.
    assign dio_in = (dio_oe & dio_out) | (~dio_oe & ext_en & ext_val) | (~dio_oe & ~ext_en);

    int count = 0;

    // The converter takes one frame per channel 0 strobe.
    always @(posedge clk) begin
        if (dac0_stb) begin
            count <= count + 1;
        end
    end
    assign frames = count;
endmodule : far_side_model

// >>> dv/test_multifunction_io_timing_core.sv
`include "mfio_params.svh"

module test_multifunction_io_timing_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata, v;
    logic [47:0] dio_in, dio_out, dio_oe;
    logic [47:0] ext_val = 48'h0000_00c3_0000;
    logic [47:0] ext_en = 48'hffff_ffff_ffff;
    logic [15:0] dac0, dac1;
    logic stb0, stb1;
    logic [1:0] ct_evt;
    logic [50:0] vec;
    int frames, n;
    int miscompares = 0;
    int compares = 0;

    assign vec = {stb1, ct_evt, dio_out};
    always #10 core_clk = ~core_clk; // 50 MHz.

    mfio_core #(.BUF_DEPTH(2048)) i_mfio_core (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .DIO_IN(dio_in), .DIO_OUT(dio_out),
        .DIO_OE(dio_oe), .DAC0_DATA(dac0), .DAC0_STB(stb0), .DAC1_DATA(dac1), .DAC1_STB(stb1),
        .CT_EVENT(ct_evt));
    far_side_model i_far_side_model (.clk(core_clk), .dio_out(dio_out), .dio_oe(dio_oe),
        .ext_val(ext_val), .ext_en(ext_en), .dac0_stb(stb0), .dio_in(dio_in), .frames(frames));

    // The strobe drops one edge later, so calls never collide in one time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge core_clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Counts the cycles in which one watched bit is high.
    task automatic tally(input int b, input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            #1 n += int'(vec[b]);
        end
    endtask : tally

    // Line 20 rises once; the gap keeps ticks far apart.
    task automatic pulse20();
        @(posedge core_clk);
        ext_val[20] <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_val[20] <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
    endtask : pulse20

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        check(dio_oe, 48'h0);
        wr(`REG_DIO_DIR, 32'h0000_0201);
        wr(`REG_DIO_PORT0, 32'h77);
        wr(`REG_DIO_PORT0 + 8'h14, 32'hff);
        repeat (2) @(posedge core_clk);
        #1 check(dio_oe, 48'h0200_0000_00ff);
        check(dio_out & 48'h0200_0000_00ff, 48'h0200_0000_0077);
        rd(`REG_DIO_PORT0 + 8'h08, v);
        check({16'h0, v}, 48'hc3);
        rd(8'hfc, v);
        check({16'h0, v}, 48'h0);
        $display("test dio done");
        wr(`REG_WAVE_ADDR, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(`REG_WAVE_DATA, 32'h1000 + i);
        end
        wr(`REG_WAVE_LEN, 32'h2);
        wr(`REG_WAVE_CFG, 32'h8);
        wr(`REG_WAVE_CMD, 32'h1);
        wr(`REG_WAVE_CMD, 32'h8);
        tally(50, 6);
        check(48'(n), 48'h1);
        #1 check({16'h0, dac0, dac1}, 48'h1000_1001);
        wr(`REG_WAVE_CFG, 32'h9);
        pulse20();
        check({16'h0, dac0, dac1}, 48'h1002_1003);
        pulse20();
        check(48'(frames), 48'h2);
        rd(`REG_WAVE_STAT, v);
        check({36'h0, v[11:0]}, 48'h0);
        wr(`REG_WAVE_CFG, 32'h4);
        wr(`REG_WAVE_CMD, 32'h1);
        wr(`REG_WAVE_CMD, 32'h8);
        repeat (4) @(posedge core_clk);
        wr(`REG_WAVE_CMD, 32'h2);
        rd(`REG_WAVE_STAT, v);
        check({16'h0, v}, 48'h2);
        wr(`REG_WAVE_CMD, 32'h1);
        wr(`REG_WAVE_CMD, 32'h8);
        repeat (4) @(posedge core_clk);
        #1 check({32'h0, dac0}, 48'h1001);
        rd(`REG_WAVE_STAT, v);
        check({16'h0, v}, 48'h1);
        wr(`REG_WAVE_CMD, 32'h4);
        rd(`REG_WAVE_STAT, v);
        check({16'h0, v}, 48'h0);
        $display("test wave done");
        wr(8'h84, 32'h4);
        wr(8'h88, 32'h1);
        wr(8'h80, 32'h7);
        tally(40, 8);
        check(48'(n), 48'h2);
        check(48'(dio_oe[40]), 48'h1);
        $display("test pwm done");
        wr(8'ha4, 32'h4);
        wr(8'ha0, 32'h3);
        wr(8'h64, 32'h5);
        wr(8'h60, 32'h1b);
        tally(48, 20);
        check(48'(n), 48'h4);
        tally(42, 20);
        check(48'(n), 48'h4);
        check(48'(dio_oe[42]), 48'h1);
        wr(8'h60, 32'h0);
        wr(8'h60, 32'h1);
        repeat (3) begin
            repeat (2) @(posedge core_clk);
            ext_val[42] <= 1'b1;
            repeat (2) @(posedge core_clk);
            ext_val[42] <= 1'b0;
        end
        rd(8'h68, v);
        check({16'h0, v}, 48'h1);
        check(48'(dio_oe[42]), 48'h0);
        $display("test counter done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check(dio_oe, 48'h0);
        $display("test second reset done");
        end_of_test();
    end
endmodule : test_multifunction_io_timing_core
